// ===== core/pgsm_pkg.sv
// constants and types shared by the password guarded serial memory slave
package pgsm_pkg;

  // ------------------------------------------------------------
  // command bytes
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_READ_HI = 4'h8;
  localparam logic [3:0] CMD_WRITE_HI = 4'h9;
  localparam logic [3:0] CMD_CHG_READ_HI = 4'ha;
  localparam logic [3:0] CMD_CHG_WRITE_HI = 4'hb;
  localparam logic [7:0] CMD_CHG_RESET = 8'hc0;
  localparam logic [7:0] CMD_RESET_PW = 8'he0;
  localparam logic [7:0] CMD_RESET_DEV = 8'he8;
  localparam logic [7:0] CMD_ACK_POLL = 8'hf0;
  localparam int CMD_ARRAY_BIT = 3;

  // ------------------------------------------------------------
  // password slots
  // ------------------------------------------------------------
  localparam int PW_SLOTS = 5;
  localparam int PW_BYTES = 8;
  localparam int PW_BITS = 64;
  localparam logic [2:0] PW_READ0 = 3'h0;
  localparam logic [2:0] PW_WRITE0 = 3'h2;
  localparam logic [2:0] PW_RESET = 3'h4;
  localparam logic [PW_BITS-1:0] PW_DELIVERY = 64'h0000000000000000;

  // ------------------------------------------------------------
  // retry counter and response to reset
  // ------------------------------------------------------------
  localparam int RETRY_LIMIT = 8;
  localparam int RESP_BITS = 32;
  localparam logic [31:0] RESP_PATTERN = 32'h1941aa55;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 25000000;
  localparam longint NV_WRITE_MS = 10;
  localparam int NV_CYCLES = int'((NV_WRITE_MS * CLK_HZ) / 1000);
  localparam int BUSY_W = 24;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_NACK} pgsm_bit_t;
  typedef enum logic [1:0] {PH_CMD, PH_PW, PH_DONE, PH_DATA} pgsm_phase_t;

endpackage : pgsm_pkg

// ===== core/pgsm_slave.sv
// two-wire password guarded serial memory slave: protocol, retry counter, reset response
//
// Behaviour
// (RQ1) reset strobe shifts out fixed 32-bit pattern
// (RQ2) no reset response during nonvolatile write
// (RQ3) host keeps reset strobe low otherwise
// (RQ4) drive data only for ack or output
// (RQ5) host sends start, command, 8-byte password
// (RQ6) data only after good password and poll
// (RQ7) all passwords are zero on delivery
// (RQ8) eight-bit units, each acknowledged by receiver
// (RQ9) command during write cycle gets no acknowledge
// (RQ10) stop before write cycle abandons, goes standby
// (RQ11) retry counter counts bad passwords, tolerates eight
// (RQ12) overflow wipes arrays, locks, keeps passwords
// (RQ13) good password before overflow clears counter
// (RQ14) data changes only while clock low
// (RQ15) ignore bus until a start is seen
// (RQ16) start during input aborts and resets
// (RQ17) no start/stop while driving or writing
// (RQ18) stop during input resets to standby
// (RQ19) release after eight bits, ack ninth
// (RQ20) reset device before overflow clears counter only
// (RQ21) after overflow only good reset-device unlocks
// (RQ22) reset password wipes arrays, zeroes passwords
// (RQ23) poll command f0 needs no password
// (RQ24) poll after bad password gets no acknowledge
// (RQ25) unknown command: no acknowledge, standby
// (RQ26) one pattern bit per serial clock
`timescale 1ns/1ps
`default_nettype none

module pgsm_slave #(
  parameter int NV_CYCLES = pgsm_pkg::NV_CYCLES,
  parameter int RETRY_LIMIT = pgsm_pkg::RETRY_LIMIT
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // two-wire link
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic rst_resp,
  // password storage load from the cell side
  input wire logic pw_load,
  input wire logic [2:0] pw_sel,
  input wire logic [63:0] pw_value,
  // user side
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic access_ok,
  output logic [7:0] access_cmd,
  output logic wipe,
  output logic locked,
  output logic busy,
  output logic [3:0] retry_count
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (NV_CYCLES < 1 || NV_CYCLES >= (1 << pgsm_pkg::BUSY_W))
  begin : g_bad_nv
    $error("NV_CYCLES out of range");
  end
  if (RETRY_LIMIT < 1 || RETRY_LIMIT > 14)
  begin : g_bad_retry
    $error("RETRY_LIMIT out of range");
  end

  localparam logic [pgsm_pkg::BUSY_W-1:0] NV_LOAD = pgsm_pkg::BUSY_W'(NV_CYCLES);
  localparam logic [3:0] RETRY_TOP = 4'(RETRY_LIMIT);

  // ------------------------------------------------------------
  // state, system clock domain
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [1:0] rr_s;
    pgsm_pkg::pgsm_bit_t st;
    pgsm_pkg::pgsm_phase_t ph;
    logic full;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic after_idle;
    logic [7:0] cmd;
    logic [2:0] pwsel;
    logic [2:0] pwi;
    logic pw_bad;
    logic pending;
    logic pass_ok;
    logic granted;
    logic [3:0] retry;
    logic locked;
    logic [pgsm_pkg::BUSY_W-1:0] busy_cnt;
    logic busy;
    logic [7:0] rx_data;
    logic rx_valid;
    logic wipe;
    logic [pgsm_pkg::PW_SLOTS-1:0][pgsm_pkg::PW_BITS-1:0] pw;
  } pgsm_state_t;

  // ------------------------------------------------------------
  // state, link clock domain (falling edge of the serial clock)
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] busy_s;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic act;
  } pgsm_link_t;

  pgsm_state_t s_r;
  pgsm_state_t s_nxt;
  pgsm_link_t l_r;
  pgsm_link_t l_nxt;

  // valid command check and password slot selection
  function automatic logic [3:0] cmd_decode(input logic [7:0] b);
    logic [3:0] r;
    r = 4'h0;
    if (b[2:0] == 3'h0)
    begin
      case (b[7:4])
        pgsm_pkg::CMD_READ_HI, pgsm_pkg::CMD_CHG_READ_HI:
          r = {1'b1, pgsm_pkg::PW_READ0 + {2'h0, b[pgsm_pkg::CMD_ARRAY_BIT]}};
        pgsm_pkg::CMD_WRITE_HI, pgsm_pkg::CMD_CHG_WRITE_HI:
          r = {1'b1, pgsm_pkg::PW_WRITE0 + {2'h0, b[pgsm_pkg::CMD_ARRAY_BIT]}};
        default:
          r = 4'h0;
      endcase
    end
    if (b == pgsm_pkg::CMD_CHG_RESET || b == pgsm_pkg::CMD_RESET_PW ||
        b == pgsm_pkg::CMD_RESET_DEV)
    begin
      r = {1'b1, pgsm_pkg::PW_RESET};
    end
    return r;
  endfunction : cmd_decode

  // ------------------------------------------------------------
  // protocol engine
  // ------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic quiet;
    logic rr_busy;
    logic [3:0] dec;
    logic [7:0] b;
    logic [7:0] ref_byte;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    quiet = 1'b0;
    rr_busy = 1'b0;
    dec = 4'h0;
    b = 8'h00;
    ref_byte = 8'h00;
    s_nxt = s_r;
    s_nxt.rx_valid = 1'b0;
    s_nxt.wipe = 1'b0;
    s_nxt.scl_s = {s_r.scl_s[1:0], scl};
    s_nxt.sda_s = {s_r.sda_s[1:0], sda_i};
    if (s_r.scl_s[2] == s_r.scl_s[1])
    begin
      s_nxt.scl_f = s_r.scl_s[1];
    end
    if (s_r.sda_s[2] == s_r.sda_s[1])
    begin
      s_nxt.sda_f = s_r.sda_s[1];
    end
    s_nxt.rr_s = {s_r.rr_s[0], l_r.act};
    rr_busy = s_r.rr_s[1];
    rise = !s_r.scl_f && s_nxt.scl_f;
    fall = s_r.scl_f && !s_nxt.scl_f;
    start = s_r.scl_f && s_nxt.scl_f && s_r.sda_f && !s_nxt.sda_f; // [RQ14]
    stop = s_r.scl_f && s_nxt.scl_f && !s_r.sda_f && s_nxt.sda_f; // [RQ14]
    // our own ack or a pattern bit on the line cannot be a start or stop
    quiet = (s_r.st == pgsm_pkg::ST_ACK) || rr_busy; // [RQ17]
    // the write timer runs on regardless of bus events
    if (s_r.busy_cnt != '0)
    begin
      s_nxt.busy_cnt = s_r.busy_cnt - 1'b1; // [RQ17]
    end
    if (pw_load)
    begin
      s_nxt.pw[pw_sel] = pw_value;
    end
    if (rr_busy)
    begin
      s_nxt.st = pgsm_pkg::ST_IDLE;
      s_nxt.ph = pgsm_pkg::PH_CMD;
      s_nxt.pending = 1'b0;
      s_nxt.granted = 1'b0;
    end
    else if (!quiet && start)
    begin
      s_nxt.st = pgsm_pkg::ST_RX; // [RQ15]
      s_nxt.ph = pgsm_pkg::PH_CMD; // [RQ16]
      s_nxt.bitn = 3'h0;
      s_nxt.full = 1'b0;
      s_nxt.pending = 1'b0; // [RQ16]
      s_nxt.granted = 1'b0;
    end
    else if (!quiet && stop)
    begin
      s_nxt.st = pgsm_pkg::ST_IDLE; // [RQ18]
      s_nxt.ph = pgsm_pkg::PH_CMD; // [RQ10]
      s_nxt.full = 1'b0;
      s_nxt.granted = 1'b0;
      s_nxt.pending = 1'b0;
      if (s_r.pending)
      begin
        // a stop after all eight password bytes always starts a nonvolatile cycle
        s_nxt.busy_cnt = NV_LOAD;
        if (!s_r.pw_bad && !(s_r.locked && s_r.cmd != pgsm_pkg::CMD_RESET_DEV))
        begin
          s_nxt.retry = 4'h0; // [RQ13] [RQ20]
          s_nxt.pass_ok = 1'b1;
          if (s_r.cmd == pgsm_pkg::CMD_RESET_DEV)
          begin
            s_nxt.locked = 1'b0; // [RQ21]
          end
          if (s_r.cmd == pgsm_pkg::CMD_RESET_PW)
          begin
            s_nxt.wipe = 1'b1; // [RQ22]
            s_nxt.pw = '0; // [RQ22]
          end
        end
        else
        begin
          s_nxt.pass_ok = 1'b0;
          if (!s_r.locked)
          begin
            if (s_r.retry == RETRY_TOP)
            begin
              s_nxt.wipe = 1'b1; // [RQ12]
              s_nxt.locked = 1'b1; // [RQ12]
            end
            else
            begin
              s_nxt.retry = s_r.retry + 1'b1; // [RQ11]
            end
          end
        end
      end
    end
    else
    begin
      case (s_r.st)
        pgsm_pkg::ST_IDLE:
        begin
          s_nxt.st = pgsm_pkg::ST_IDLE; // [RQ15]
        end
        pgsm_pkg::ST_RX:
        begin
          if (rise && !s_r.full)
          begin
            s_nxt.sh = {s_r.sh[6:0], s_nxt.sda_f}; // [RQ8]
            s_nxt.bitn = s_r.bitn + 1'b1;
            s_nxt.full = (s_r.bitn == 3'h7);
          end
          else if (fall && s_r.full)
          begin
            // byte done: settle the ninth-clock answer now, while clock is low
            b = s_r.sh;
            s_nxt.full = 1'b0;
            s_nxt.bitn = 3'h0;
            s_nxt.st = pgsm_pkg::ST_NACK;
            s_nxt.after_idle = 1'b1;
            case (s_r.ph)
              pgsm_pkg::PH_CMD:
              begin
                dec = cmd_decode(b);
                if (b == pgsm_pkg::CMD_ACK_POLL)
                begin
                  if (!s_r.busy && s_r.pass_ok) // [RQ23] [RQ24] [RQ9]
                  begin
                    s_nxt.st = pgsm_pkg::ST_ACK;
                    s_nxt.after_idle = 1'b0;
                    s_nxt.ph = pgsm_pkg::PH_DATA;
                    s_nxt.granted = 1'b1; // [RQ6]
                  end
                end
                else if (s_r.busy)
                begin
                  s_nxt.st = pgsm_pkg::ST_NACK; // [RQ9]
                end
                else if (!dec[3])
                begin
                  s_nxt.st = pgsm_pkg::ST_NACK; // [RQ25]
                end
                else if (s_r.locked && b != pgsm_pkg::CMD_RESET_DEV)
                begin
                  s_nxt.st = pgsm_pkg::ST_NACK; // [RQ21]
                end
                else
                begin
                  s_nxt.st = pgsm_pkg::ST_ACK;
                  s_nxt.after_idle = 1'b0;
                  s_nxt.ph = pgsm_pkg::PH_PW;
                  s_nxt.cmd = b;
                  s_nxt.pwsel = dec[2:0];
                  s_nxt.pwi = 3'h0;
                  s_nxt.pw_bad = 1'b0;
                  s_nxt.pass_ok = 1'b0;
                end
              end
              pgsm_pkg::PH_PW:
              begin
                // most significant byte of the stored password comes first
                ref_byte = s_r.pw[s_r.pwsel][(7 - s_r.pwi) * 8 +: 8];
                s_nxt.pw_bad = s_r.pw_bad || (b != ref_byte);
                s_nxt.pwi = s_r.pwi + 1'b1;
                s_nxt.st = pgsm_pkg::ST_ACK; // [RQ8]
                s_nxt.after_idle = 1'b0;
                if (s_r.pwi == 3'(pgsm_pkg::PW_BYTES - 1))
                begin
                  s_nxt.ph = pgsm_pkg::PH_DONE;
                  s_nxt.pending = 1'b1;
                end
              end
              pgsm_pkg::PH_DATA:
              begin
                s_nxt.st = pgsm_pkg::ST_ACK; // [RQ6]
                s_nxt.after_idle = 1'b0;
                s_nxt.rx_data = b;
                s_nxt.rx_valid = 1'b1;
              end
              default:
              begin
                s_nxt.pending = 1'b0;
              end
            endcase
          end
        end
        pgsm_pkg::ST_ACK, pgsm_pkg::ST_NACK:
        begin
          // entered at the eighth fall, left at the ninth fall
          if (fall)
          begin
            s_nxt.st = s_r.after_idle ? pgsm_pkg::ST_IDLE : pgsm_pkg::ST_RX; // [RQ19]
            if (s_r.after_idle)
            begin
              s_nxt.ph = pgsm_pkg::PH_CMD; // [RQ25]
            end
          end
        end
        default:
        begin
          s_nxt.st = pgsm_pkg::ST_IDLE;
        end
      endcase
    end
    s_nxt.busy = (s_nxt.busy_cnt != '0);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
               st: pgsm_pkg::ST_IDLE, ph: pgsm_pkg::PH_CMD,
               pw: {pgsm_pkg::PW_SLOTS{pgsm_pkg::PW_DELIVERY}}, // [RQ7]
               default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // response to reset, serial clock domain
  // ------------------------------------------------------------
  always_comb
  begin
    l_nxt = l_r;
    l_nxt.busy_s = {l_r.busy_s[0], s_r.busy};
    if (l_r.cnt != 6'h00)
    begin
      l_nxt.sh = {l_r.sh[30:0], 1'b0}; // [RQ26]
      l_nxt.cnt = l_r.cnt - 1'b1;
    end
    else if (rst_resp && !l_r.busy_s[1]) // [RQ2] [RQ3]
    begin
      l_nxt.sh = pgsm_pkg::RESP_PATTERN; // [RQ1]
      l_nxt.cnt = 6'(pgsm_pkg::RESP_BITS);
    end
    l_nxt.act = (l_nxt.cnt != 6'h00);
  end

  // pattern bits change on the falling edge, so they are stable while clock is high
  always_ff @(negedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_r <= '0;
    end
    else
    begin
      l_r <= l_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // push-pull during the pattern, low-only during an acknowledge
  assign sda_oe_n = !((s_r.st == pgsm_pkg::ST_ACK) || l_r.act); // [RQ4] [RQ19]
  assign sda_o = l_r.act & l_r.sh[31]; // [RQ1]
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign access_ok = s_r.granted;
  assign access_cmd = s_r.cmd;
  assign wipe = s_r.wipe;
  assign locked = s_r.locked;
  assign busy = s_r.busy;
  assign retry_count = s_r.retry;

endmodule : pgsm_slave

`default_nettype wire

// ===== bench/pgsm_slave_properties.sv
// port assertions for the serial memory slave
`timescale 1ns/1ps
`default_nettype none

module pgsm_slave_properties #(
  parameter int RETRY_LIMIT = 8
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // link and status
  input wire logic sda_oe_n,
  input wire logic rx_valid,
  input wire logic access_ok,
  input wire logic wipe,
  input wire logic locked,
  input wire logic busy,
  input wire logic [3:0] retry_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // retry counter and lock
  // ------------------------------------------------------------
  property p_cnt_max;
    int'(retry_count) <= RETRY_LIMIT;
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("retry count above limit");
  property p_retry_step;
    $changed(retry_count) |-> retry_count == $past(retry_count) + 4'h1 || retry_count == 4'h0;
  endproperty
  a_retry_step: assert property (p_retry_step)
    else $error("retry count moved by other than one or clear");
  property p_lock_at_limit;
    $rose(locked) |-> int'(retry_count) == RETRY_LIMIT;
  endproperty
  a_lock_at_limit: assert property (p_lock_at_limit)
    else $error("lock set below the retry limit");
  property p_frozen;
    locked ##1 locked |-> $stable(retry_count);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("retry count moved while locked");
  property p_wipe_pulse;
    wipe |=> !wipe;
  endproperty
  a_wipe_pulse: assert property (p_wipe_pulse)
    else $error("wipe longer than one cycle");
  // ------------------------------------------------------------
  // link and data
  // ------------------------------------------------------------
  property p_busy_quiet;
    busy |-> sda_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data line driven during write cycle");
  property p_rx_access;
    rx_valid |-> access_ok;
  endproperty
  a_rx_access: assert property (p_rx_access)
    else $error("data byte taken without access");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("byte strobe longer than one cycle");
  property p_drive_bounded;
    $fell(sda_oe_n) |-> ##[1:100] sda_oe_n;
  endproperty
  a_drive_bounded: assert property (p_drive_bounded)
    else $error("data line held too long");
  c_lock: cover property ($rose(locked));
  c_rx: cover property (rx_valid);
  c_wipe: cover property (wipe);
  c_drive: cover property ($fell(sda_oe_n));
endmodule : pgsm_slave_properties

`default_nettype wire

// ===== bench/pgsm_host.sv
// two-wire bus master model with reset strobe
`timescale 1ns/1ps
`default_nettype none

module pgsm_host (
  // link pins
  output logic scl,
  output logic sda_drv,
  output logic rst_resp,
  input wire logic sda,
  // observed results
  output logic ack_stb,
  output logic ack_bit,
  output logic resp_stb,
  output logic [31:0] resp_word
);
  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  // 4.8 system clock periods a quarter, slow enough for the 3-flop filter
  localparam int Q = 192;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rst_resp = 1'b0;
    ack_stb = 1'b0;
    resp_stb = 1'b0;
  end
  // data moves only in the low half, a quarter after the fall
  task automatic bit_io(input logic b, output logic s);
    #Q sda_drv = b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #Q sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack_bit = s;
    ack_stb = 1'b1;
    #1 ack_stb = 1'b0;
  endtask : send
  // 48 ns clock for the four idle pulses and inside the frame; idle pulses let busy reach the link side
  task automatic resp();
    repeat (4)
    begin
      #24 scl = 1'b0;
      #24 scl = 1'b1;
    end
    rst_resp = 1'b1;
    #12 scl = 1'b0;
    #12 rst_resp = 1'b0;
    for (int k = 31; k >= 0; k--)
    begin
      resp_word[k] = sda;
      #12 scl = 1'b1;
      #24 scl = 1'b0;
      #12;
    end
    #12 scl = 1'b1;
    resp_stb = 1'b1;
    #1 resp_stb = 1'b0;
  endtask : resp
endmodule : pgsm_host

`default_nettype wire

// ===== bench/pgsm_slave_tb.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none

module pgsm_slave_tb;
  localparam int RETRY_LIMIT = 8;
  logic clk, rst_n, pw_load, scl, sda_drv, rst_resp, sda, ack_stb, ack_bit, resp_stb;
  logic sda_o, sda_oe_n, rx_valid, access_ok, wipe, locked, busy;
  logic [2:0] pw_sel;
  logic [3:0] retry_count;
  logic [7:0] rx_data, d, access_cmd;
  logic [7:0] cmds [4] = '{8'h80, 8'h88, 8'h90, 8'h98};
  logic [31:0] resp_word;
  logic [63:0] pw_value, rpw, rp1;
  logic [31:0] exp_q [$];
  int error_cnt = 0;
  int cmp_count = 0;
  int wipe_cnt = 0;
  // pull-up: released by both parties reads high
  assign sda = (sda_oe_n | sda_o) & sda_drv;
  always #20 clk = ~clk;
  pgsm_slave #(.NV_CYCLES(200), .RETRY_LIMIT(RETRY_LIMIT)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .rst_resp(rst_resp), .pw_load(pw_load), .pw_sel(pw_sel), .pw_value(pw_value),
    .rx_data(rx_data), .rx_valid(rx_valid), .access_ok(access_ok), .access_cmd(access_cmd),
    .wipe(wipe), .locked(locked), .busy(busy), .retry_count(retry_count));
  pgsm_host i_host (
    .scl(scl), .sda_drv(sda_drv), .rst_resp(rst_resp), .sda(sda), .ack_stb(ack_stb),
    .ack_bit(ack_bit), .resp_stb(resp_stb), .resp_word(resp_word));
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  always @(posedge ack_stb) chk("ack", exp_q.pop_front(), {31'h0, ack_bit});
  always @(posedge resp_stb) chk("resp", exp_q.pop_front(), resp_word);
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      chk("rx", exp_q.pop_front(), {24'h0, rx_data});
    if (wipe === 1'b1)
      wipe_cnt++;
  end
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 2000 && busy !== v; n++)
      @(posedge clk);
    chk("busy", {31'h0, v}, {31'h0, busy});
  endtask : wait_busy
  // command, password, probe during the write cycle, then poll left open
  task automatic seq(input logic [7:0] c, input logic [63:0] p, input logic pe, input logic pr);
    i_host.start();
    exp_q.push_back(32'h0);
    i_host.send(c);
    for (int i = 7; i >= 0; i--)
    begin
      exp_q.push_back(32'h0);
      i_host.send(p[i*8 +: 8]);
    end
    i_host.stop();
    wait_busy(1'b1);
    exp_q.push_back(pr ? 32'hffffffff : 32'h1);
    if (pr)
      i_host.resp();
    else
    begin
      i_host.start();
      i_host.send(pgsm_pkg::CMD_ACK_POLL);
      i_host.stop();
    end
    wait_busy(1'b0);
    i_host.start();
    exp_q.push_back({31'h0, pe});
    i_host.send(pgsm_pkg::CMD_ACK_POLL);
  endtask : seq
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    pw_load = 1'b0;
    pw_sel = 3'h0;
    pw_value = 64'h0;
    void'($urandom(62166));
    rpw = {$urandom(), $urandom()};
    rp1 = {$urandom(), $urandom()};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    pw_load <= 1'b1;
    pw_sel <= 3'h1;
    pw_value <= rp1;
    @(posedge clk);
    pw_sel <= pgsm_pkg::PW_RESET;
    pw_value <= rpw;
    @(posedge clk);
    pw_load <= 1'b0;
    chk("oe", 32'h1, {31'h0, sda_oe_n});
    exp_q.push_back(pgsm_pkg::RESP_PATTERN);
    i_host.resp();
    i_host.start();
    exp_q.push_back(32'h1);
    i_host.send(8'h55);
    i_host.stop();
    seq(8'h80, {$urandom(), $urandom()} | 64'h1, 1'b1, 1'b1);
    i_host.stop();
    chk("retry", 32'h1, {28'h0, retry_count});
    seq(8'h80, pgsm_pkg::PW_DELIVERY, 1'b0, 1'b0);
    chk("retry", 32'h0, {28'h0, retry_count});
    chk("access", 32'h1, {31'h0, access_ok});
    chk("cmd", 32'h80, {24'h0, access_cmd});
    d = 8'($urandom());
    exp_q.push_back({24'h0, d});
    exp_q.push_back(32'h0);
    i_host.send(d);
    i_host.stop();
    repeat (6) @(posedge clk);
    chk("access", 32'h0, {31'h0, access_ok});
    for (int k = 0; k < 4; k++)
    begin
      // even k opens a frame; the start at k == 2 cuts the password short
      if (!k[0])
        i_host.start();
      exp_q.push_back(32'h0);
      i_host.send(k[0] ? 8'h00 : cmds[k]);
    end
    i_host.stop();
    repeat (20) @(posedge clk);
    chk("busy", 32'h0, {31'h0, busy});
    for (int k = 1; k <= 9; k++)
    begin
      seq(cmds[k % 4], {$urandom(), $urandom()} | 64'h1, 1'b1, 1'b0);
      i_host.stop();
      chk("retry", (k > 8) ? 32'h8 : 32'(k), {28'h0, retry_count});
    end
    chk("locked", 32'h1, {31'h0, locked});
    chk("wipes", 32'h1, 32'(wipe_cnt));
    i_host.start();
    exp_q.push_back(32'h1);
    i_host.send(8'h80);
    i_host.stop();
    seq(pgsm_pkg::CMD_RESET_DEV, rpw, 1'b0, 1'b0);
    i_host.stop();
    chk("locked", 32'h0, {31'h0, locked});
    seq(8'h90, 64'h1, 1'b1, 1'b0);
    i_host.stop();
    seq(pgsm_pkg::CMD_RESET_DEV, rpw, 1'b0, 1'b0);
    i_host.stop();
    chk("retry", 32'h0, {28'h0, retry_count});
    chk("wipes", 32'h1, 32'(wipe_cnt));
    seq(8'h88, rp1, 1'b0, 1'b0);
    i_host.stop();
    chk("cmd", 32'h88, {24'h0, access_cmd});
    seq(pgsm_pkg::CMD_RESET_PW, rpw, 1'b0, 1'b0);
    i_host.stop();
    chk("wipes", 32'h2, 32'(wipe_cnt));
    seq(8'h88, 64'h0, 1'b0, 1'b0);
    i_host.stop();
    seq(pgsm_pkg::CMD_RESET_DEV, 64'h0, 1'b0, 1'b0);
    i_host.stop();
    complete_run();
  end
  initial
  begin
    #3000000;
    error_cnt++;
    complete_run();
  end
endmodule : pgsm_slave_tb

bind pgsm_slave pgsm_slave_properties #(.RETRY_LIMIT(RETRY_LIMIT)) i_props (
  .clk(clk), .rst_n(rst_n), .sda_oe_n(sda_oe_n), .rx_valid(rx_valid), .access_ok(access_ok),
  .wipe(wipe), .locked(locked), .busy(busy), .retry_count(retry_count));

`default_nettype wire
